// [ccms_map.svh]
// Constants for the CPU clock mode selector
`ifndef CCMS_MAP_SVH
`define CCMS_MAP_SVH

// ---------------------------------------------------------------
// Oscillator tick positions
// ---------------------------------------------------------------
`define CCMS_SRC_MAIN    0
`define CCMS_SRC_SUB     1
`define CCMS_SRC_INT     2
`define CCMS_SRC_SYNTH   3
`define CCMS_NUM_SRC     4

// ---------------------------------------------------------------
// Divider field codes and terminal counts
// ---------------------------------------------------------------
`define CCMS_DIV_CODE_1  2'h0
`define CCMS_DIV_CODE_2  2'h1
`define CCMS_DIV_CODE_4  2'h2
`define CCMS_DIV_CODE_16 2'h3
`define CCMS_LAST_1      4'h0
`define CCMS_LAST_2      4'h1
`define CCMS_LAST_4      4'h3
`define CCMS_LAST_8      4'h7
`define CCMS_LAST_16     4'hF
`define CCMS_CNT_ZERO    4'h0
`define CCMS_CNT_ONE     4'h1

// ---------------------------------------------------------------
// Clock output select codes and tap bits
// ---------------------------------------------------------------
`define CCMS_CO_PORT     2'h0
`define CCMS_CO_F8       2'h1
`define CCMS_CO_F32      2'h2
`define CCMS_CO_FC       2'h3
`define CCMS_TAP_F8      2
`define CCMS_TAP_F32     4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CCMS_RST_DIV8    1'b1
`define CCMS_RST_PREDIV  2'h0
`define CCMS_RST_MULT    3'h0

`endif

// [ccms_pkg.sv]
// Types for the CPU clock mode selector
package ccms_pkg;

  // -------------------------------------------------------------
  // Normal operating modes, one-hot
  // -------------------------------------------------------------
  typedef enum logic [6:0] {
    CCMS_HIGH      = 7'h01,
    CCMS_SYNTH     = 7'h02,
    CCMS_MEDIUM    = 7'h04,
    CCMS_LOW_SPEED = 7'h08,
    CCMS_LOW_POWER = 7'h10,
    CCMS_INT_OSC   = 7'h20,
    CCMS_INT_LP    = 7'h40
  } ccms_mode_type;

endpackage : ccms_pkg

// [ccms_osc_sync.sv]
// Oscillator level synchroniser with rising-edge tick
`timescale 1ns/10ps

module ccms_osc_sync #(
  parameter int NUM = 4
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           ce,
  input  wire logic [NUM-1:0] osc_level,
  output logic      [NUM-1:0] osc_tick
);

  logic [NUM-1:0] meta_q;
  logic [NUM-1:0] sync_q;
  logic [NUM-1:0] last_q;

  generate
    if (NUM < 1) begin : g_bad
      $error("ccms_osc_sync needs NUM of at least 1");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Two stages, then edge detect on the second only
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else if (ce) begin
      meta_q <= osc_level;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign osc_tick = sync_q & ~last_q;

endmodule : ccms_osc_sync

// [ccms_clock_ctrl.sv]
// CPU clock source, divider, peripheral gating and mode decode
`timescale 1ns/10ps
`include "ccms_map.svh"

// What this block does
// R1 - CPU source is main, sub, internal 125 kHz or synthesizer clock.
// R2 - Main, synthesizer or internal source divides by 1, 2, 4, 8, 16.
// R3 - After reset the CPU runs from internal oscillator divided by 8.
// R4 - In expansion modes with disable bit 0, bus clock follows CPU clock.
// R5 - Divide-by-8 bit sets on stop entry or main-off in low-speed mode.
// R6 - Peripheral clock gated in wait with stop bit, always in low power.
// R7 - Sub timer clock comes from sub oscillator, only while it runs.
// R8 - Internal timer clock offered only while its stop bit is 0.
// R9 - Single-chip clock output picks periph/8, periph/32 or sub clock.
// R10 - Software switches source only after it oscillates stably.
// R11 - Internal to main switch goes through divide-by-8 first.
// R12 - Synthesizer mode entered only from high or medium speed.
// R13 - Low-speed: sub clocks CPU; peripheral source chosen by source bit, then synthesizer select.
// R14 - Software leaves the divide-by-8 bit alone in low power mode.
// R15 - Internal oscillator mode clocks CPU and peripherals from it.
// R16 - Internal low power mode keeps the same divider choices.
// R17 - Medium speed is main clock divided by 2, 4, 8 or 16.
// R18 - High speed is the undivided main clock.
// R19 - Synthesizer pre-divider and multiplier are writable once after reset.
// R20 - Software enables synthesizer and waits for lock before selecting.
// R21 - Field 0..3 means 1, 2, 4, 16; divide-by-8 bit overrides.
// R22 - Priority: sub select, then synthesizer, then source bit.
module ccms_clock_ctrl #(
  parameter int PCNT_W = 5
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  main_osc_level,
  input  wire logic                  sub_osc_level,
  input  wire logic                  int_osc_level,
  input  wire logic                  synth_osc_level,
  input  wire logic                  div8_wr,
  input  wire logic                  div8_wdata,
  input  wire logic                  cpu_div_field_hi,
  input  wire logic                  cpu_div_field_lo,
  input  wire logic                  sub_clock_cpu_select,
  input  wire logic                  synth_cpu_select,
  input  wire logic                  int_osc_stop,
  input  wire logic                  periph_source_int_osc,
  input  wire logic                  main_osc_off,
  input  wire logic                  sub_osc_enable,
  input  wire logic                  periph_stop_in_wait,
  input  wire logic                  clk_out_sel_hi,
  input  wire logic                  clk_out_sel_lo,
  input  wire logic                  bus_clk_out_disable,
  input  wire logic                  expansion_mode,
  input  wire logic                  wait_mode,
  input  wire logic                  stop_enter,
  input  wire logic                  synth_run,
  input  wire logic                  synth_cfg_wr,
  input  wire logic                  synth_prediv_hi,
  input  wire logic                  synth_prediv_lo,
  input  wire logic                  synth_mult_hi,
  input  wire logic [1:0]            synth_mult_lo,
  output logic                       cpu_clk_en_q,
  output logic                       bus_clk_pin_q,
  output logic                       primary_periph_clock_q,
  output logic                       sub_timer_clock_q,
  output logic                       int_osc_timer_clock_q,
  output logic                       clock_output_pin_q,
  output logic                       div8_select_q,
  output logic                       synth_enable_q,
  output logic [1:0]                 synth_prediv_q,
  output logic [2:0]                 synth_mult_q,
  output ccms_pkg::ccms_mode_type    mode_q
);
  import ccms_pkg::*;

  logic [`CCMS_NUM_SRC-1:0] tick;
  logic                     main_off_q;
  logic                     synth_locked_q;
  logic [3:0]               cnt_q;
  logic [PCNT_W-1:0]        pcnt_q;
  logic                     cpu_tick;
  logic                     periph_tick;
  logic                     periph_on;
  logic                     low_power;
  logic                     div8_set;
  logic [3:0]               last;
  ccms_mode_type            mode_d;

  generate
    if (PCNT_W < `CCMS_TAP_F32 + 1) begin : g_bad
      $error("PCNT_W too narrow for the divide-by-32 tap");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // R21 divider decode
  function automatic logic [3:0] div_last(input logic d8,
                                          input logic [1:0] fld);
    logic [3:0] r;
    r = `CCMS_LAST_1;
    if (d8) begin
      r = `CCMS_LAST_8;
    end else begin
      case (fld)
        `CCMS_DIV_CODE_1:  r = `CCMS_LAST_1;
        `CCMS_DIV_CODE_2:  r = `CCMS_LAST_2;
        `CCMS_DIV_CODE_4:  r = `CCMS_LAST_4;
        `CCMS_DIV_CODE_16: r = `CCMS_LAST_16;
        default:           r = `CCMS_LAST_1;
      endcase
    end
    return r;
  endfunction : div_last

  // Oscillators are foreign levels; only edges cross
  ccms_osc_sync #(
    .NUM (`CCMS_NUM_SRC)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .osc_level ({synth_osc_level, int_osc_level,
                 sub_osc_level, main_osc_level}),
    .osc_tick  (tick)
  );

  // ---------------------------------------------------------------
  // Source selection and mode decode
  // ---------------------------------------------------------------
  assign low_power = sub_clock_cpu_select & main_osc_off;
  assign last      = div_last(div8_select_q,
                              {cpu_div_field_hi, cpu_div_field_lo});

  // R1 R22 source choice and priority
  always_comb begin
    cpu_tick    = tick[`CCMS_SRC_MAIN];
    periph_tick = tick[`CCMS_SRC_MAIN];
    if (sub_clock_cpu_select) begin
      // R13 low-speed peripheral source
      cpu_tick    = tick[`CCMS_SRC_SUB];
      periph_tick = periph_source_int_osc ? tick[`CCMS_SRC_INT] :
                    synth_cpu_select ? tick[`CCMS_SRC_SYNTH] :
                    tick[`CCMS_SRC_MAIN];
    end else if (synth_cpu_select) begin
      cpu_tick    = tick[`CCMS_SRC_SYNTH];
      periph_tick = tick[`CCMS_SRC_SYNTH];
    end else if (periph_source_int_osc) begin
      // R15 internal oscillator feeds both
      cpu_tick    = tick[`CCMS_SRC_INT];
      periph_tick = tick[`CCMS_SRC_INT];
    end
  end

  always_comb begin
    mode_d = CCMS_HIGH;
    if (sub_clock_cpu_select) begin
      mode_d = main_osc_off ? CCMS_LOW_POWER : CCMS_LOW_SPEED;
    end else if (synth_cpu_select) begin
      mode_d = CCMS_SYNTH;
    end else if (periph_source_int_osc) begin
      mode_d = main_osc_off ? CCMS_INT_LP : CCMS_INT_OSC;
    end else if (last != `CCMS_LAST_1) begin
      mode_d = CCMS_MEDIUM;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= CCMS_INT_OSC;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  // ---------------------------------------------------------------
  // Divide-by-8 bit
  // ---------------------------------------------------------------
  // R5 stop entry or low-power entry detect
  assign div8_set = stop_enter |
                    (sub_clock_cpu_select & main_osc_off & ~main_off_q);

  // R3 reset to divide by 8; hardware set beats a write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div8_select_q <= `CCMS_RST_DIV8;
      main_off_q    <= 1'b0;
    end else if (ce) begin
      main_off_q <= main_osc_off;
      if (div8_set) begin
        div8_select_q <= 1'b1;
      end else if (div8_wr) begin
        div8_select_q <= div8_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // CPU divider and bus clock
  // ---------------------------------------------------------------
  // R2 R16 R17 R18 divide; sub clock is never divided
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q        <= `CCMS_CNT_ZERO;
      cpu_clk_en_q <= 1'b0;
    end else if (ce) begin
      cpu_clk_en_q <= 1'b0;
      if (cpu_tick) begin
        if (sub_clock_cpu_select || cnt_q >= last) begin
          cnt_q        <= `CCMS_CNT_ZERO;
          cpu_clk_en_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + `CCMS_CNT_ONE;
        end
      end
    end
  end

  // R4 bus clock mirrors CPU clock; idles high otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_clk_pin_q <= 1'b1;
    end else if (ce) begin
      bus_clk_pin_q <= (expansion_mode && !bus_clk_out_disable) ?
                       cpu_clk_en_q : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral and timer clocks
  // ---------------------------------------------------------------
  // R6 peripheral gating
  assign periph_on = ~low_power & ~(wait_mode & periph_stop_in_wait);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_periph_clock_q <= 1'b0;
      sub_timer_clock_q      <= 1'b0;
      int_osc_timer_clock_q  <= 1'b0;
      pcnt_q                 <= '0;
    end else if (ce) begin
      primary_periph_clock_q <= periph_tick & periph_on;
      // R7 sub timer clock
      sub_timer_clock_q      <= tick[`CCMS_SRC_SUB] & sub_osc_enable;
      // R8 internal timer clock
      int_osc_timer_clock_q  <= tick[`CCMS_SRC_INT] & ~int_osc_stop;
      if (periph_tick && periph_on) begin
        pcnt_q <= pcnt_q + 1'b1;
      end
    end
  end

  // R9 clock output select; low for port use and in bus modes
  // Sub clock leaves as one pulse per period, so its rate is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin_q <= 1'b0;
    end else if (ce) begin
      case (expansion_mode ? `CCMS_CO_PORT : {clk_out_sel_hi, clk_out_sel_lo})
        `CCMS_CO_F8:  clock_output_pin_q <= pcnt_q[`CCMS_TAP_F8];
        `CCMS_CO_F32: clock_output_pin_q <= pcnt_q[`CCMS_TAP_F32];
        `CCMS_CO_FC:  clock_output_pin_q <= tick[`CCMS_SRC_SUB];
        default:      clock_output_pin_q <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Synthesizer configuration
  // ---------------------------------------------------------------
  // R19 write-once fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_prediv_q <= `CCMS_RST_PREDIV;
      synth_mult_q   <= `CCMS_RST_MULT;
      synth_locked_q <= 1'b0;
      synth_enable_q <= 1'b0;
    end else if (ce) begin
      synth_enable_q <= synth_run;
      if (synth_cfg_wr && !synth_locked_q) begin
        synth_prediv_q <= {synth_prediv_hi, synth_prediv_lo};
        synth_mult_q   <= {synth_mult_hi, synth_mult_lo};
        synth_locked_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_lp_entry;
    ce && sub_clock_cpu_select && main_osc_off && !main_off_q;
  endsequence

  sequence s_main_hi;
    ce && mode_d == CCMS_HIGH && tick[`CCMS_SRC_MAIN];
  endsequence

  a_div8_stop_set: assert property ( // R5
    ce && stop_enter |=> div8_select_q)
    else $error("div8 not set on stop entry");
  a_div8_lp_set: assert property ( // R5
    s_lp_entry |=> div8_select_q)
    else $error("div8 not set on low power entry");
  a_periph_lp_off: assert property ( // R6
    ce && low_power |=> !primary_periph_clock_q)
    else $error("peripheral clock running in low power");
  a_periph_wait_off: assert property ( // R6
    ce && wait_mode && periph_stop_in_wait |=> !primary_periph_clock_q)
    else $error("peripheral clock running in wait");
  a_sub_timer_gate: assert property ( // R7
    ce && !sub_osc_enable |=> !sub_timer_clock_q)
    else $error("sub timer clock while sub stopped");
  a_int_timer_gate: assert property ( // R8
    ce && int_osc_stop |=> !int_osc_timer_clock_q)
    else $error("internal timer clock while stopped");
  a_synth_once: assert property ( // R19
    ce && synth_locked_q |=> $stable(synth_prediv_q) &&
                             $stable(synth_mult_q))
    else $error("synthesizer fields changed after first write");
  a_bus_clk_follow: assert property ( // R4
    ce && expansion_mode && !bus_clk_out_disable && cpu_clk_en_q
    |=> bus_clk_pin_q)
    else $error("bus clock missed a CPU clock");
  a_high_undiv: assert property ( // R18
    s_main_hi |=> cpu_clk_en_q)
    else $error("high speed clock divided");
  a_sub_undiv: assert property ( // R13
    ce && sub_clock_cpu_select && tick[`CCMS_SRC_SUB] |=> cpu_clk_en_q)
    else $error("sub clock did not clock the CPU");

endmodule : ccms_clock_ctrl

// [tb_cpu_clock_mode_select.sv]
// Self-checking bench for the CPU clock mode selector
`timescale 1ns/10ps

module tb_cpu_clock_mode_select;
  import ccms_pkg::*;
  // ---------------------------------------------------------------
  // Settings and signals
  // ---------------------------------------------------------------
  // Oscillator periods in ref_clk cycles, set by the generator below
  localparam int MP = 4;
  localparam int YP = 2;
  localparam int SP = 10;
  localparam int IP = 6;
  localparam int LIMIT = 40000;
  localparam int DIV_T [4] = '{1, 2, 4, 16};
  logic ref_clk, rst_n, ce, main_osc_level, sub_osc_level, int_osc_level;
  logic synth_osc_level, div8_wr, div8_wdata, cpu_div_field_hi;
  logic cpu_div_field_lo, sub_clock_cpu_select, synth_cpu_select;
  logic int_osc_stop, periph_source_int_osc, main_osc_off, sub_osc_enable;
  logic periph_stop_in_wait, clk_out_sel_hi, clk_out_sel_lo;
  logic bus_clk_out_disable, expansion_mode, wait_mode, stop_enter;
  logic synth_run, synth_cfg_wr, synth_prediv_hi, synth_prediv_lo;
  logic synth_mult_hi, cpu_clk_en_q, bus_clk_pin_q, primary_periph_clock_q;
  logic sub_timer_clock_q, int_osc_timer_clock_q, clock_output_pin_q;
  logic div8_select_q, synth_enable_q, primed, co_prev, ev;
  logic [1:0]    synth_mult_lo;
  logic [1:0]    synth_prediv_q;
  logic [2:0]    synth_mult_q;
  logic [31:0]   seed;
  ccms_mode_type mode_q;
  int            errors, n_checks, cyc, last, ev_cnt, msel, osc_t;
  int            exp_q [$];

  ccms_clock_ctrl #(.PCNT_W(5)) u_ccms_clock_ctrl (
    .ref_clk, .rst_n, .ce, .main_osc_level, .sub_osc_level, .int_osc_level,
    .synth_osc_level, .div8_wr, .div8_wdata, .cpu_div_field_hi,
    .cpu_div_field_lo, .sub_clock_cpu_select, .synth_cpu_select,
    .int_osc_stop, .periph_source_int_osc, .main_osc_off, .sub_osc_enable,
    .periph_stop_in_wait, .clk_out_sel_hi, .clk_out_sel_lo,
    .bus_clk_out_disable, .expansion_mode, .wait_mode, .stop_enter,
    .synth_run, .synth_cfg_wr, .synth_prediv_hi, .synth_prediv_lo,
    .synth_mult_hi, .synth_mult_lo, .cpu_clk_en_q, .bus_clk_pin_q,
    .primary_periph_clock_q, .sub_timer_clock_q, .int_osc_timer_clock_q,
    .clock_output_pin_q, .div8_select_q, .synth_enable_q, .synth_prediv_q,
    .synth_mult_q, .mode_q);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Stopped oscillators stand still, as the real circuits do
  always @(posedge ref_clk) begin
    osc_t <= osc_t + 1;
    main_osc_level <= !main_osc_off && osc_t[1];
    synth_osc_level <= synth_run && osc_t[0];
    sub_osc_level <= sub_osc_enable && ((osc_t % SP) < SP / 2);
    int_osc_level <= !int_osc_stop && ((osc_t % IP) < IP / 2);
  end

  // ---------------------------------------------------------------
  // Monitor: period between events, oldest note first
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    case (msel)
      0: ev = cpu_clk_en_q === 1'b1;
      1: ev = bus_clk_pin_q === 1'b1;
      2: ev = primary_periph_clock_q === 1'b1;
      3: ev = sub_timer_clock_q === 1'b1;
      4: ev = int_osc_timer_clock_q === 1'b1;
      5: ev = bus_clk_pin_q !== 1'b1;
      default: ev = clock_output_pin_q === 1'b1 && co_prev === 1'b0;
    endcase
    co_prev = clock_output_pin_q;
    if (exp_q.size() == 0) primed = 1'b0;
    if (ev) begin
      ev_cnt++;
      if (exp_q.size() > 0 && primed) begin
        chk_val("period", exp_q.pop_front(), cyc - last);
        primed = 1'b0;
      end else if (exp_q.size() > 0) begin
        primed = 1'b1;
      end
      last = cyc;
    end
    cyc++;
    if (cyc > LIMIT) begin
      errors++;
      $display("MISMATCH timeout expected done seen %0d cycles", cyc);
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, s);
    end
  endtask : chk_val

  task automatic chk_mode(input ccms_mode_type e);
    n_checks++;
    if (mode_q !== e) begin
      errors++;
      $display("MISMATCH mode_q expected %h seen %h", e, mode_q);
    end
  endtask : chk_mode

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] r;
    r = x ^ (x << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xorshift

  // Settles first, so a count caught mid-change is not judged
  task automatic meas(input int sel, input int e);
    int k;
    msel = sel;
    repeat (e * 3 + 20) @(posedge ref_clk);
    exp_q.push_back(e);
    k = 0;
    while (exp_q.size() > 0 && k < e * 4 + 60) begin
      @(posedge ref_clk);
      k++;
    end
    if (exp_q.size() > 0) begin
      errors++;
      $display("MISMATCH period expected %0d seen none", e);
      exp_q.delete();
    end
  endtask : meas

  task automatic count_ev(input int sel, input int n, output int c);
    int s;
    msel = sel;
    repeat (20) @(posedge ref_clk);
    s = ev_cnt;
    repeat (n) @(posedge ref_clk);
    c = ev_cnt - s;
  endtask : count_ev

  task automatic set_src(input logic s, input logic y, input logic p,
                         input logic [1:0] f);
    @(posedge ref_clk);
    sub_clock_cpu_select <= s;
    synth_cpu_select <= y;
    periph_source_int_osc <= p;
    {cpu_div_field_hi, cpu_div_field_lo} <= f;
  endtask : set_src

  task automatic wr_div8(input logic v);
    @(posedge ref_clk);
    div8_wr <= 1'b1;
    div8_wdata <= v;
    @(posedge ref_clk);
    div8_wr <= 1'b0;
  endtask : wr_div8

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int c;
    logic [1:0] f;
    {div8_wr, div8_wdata, cpu_div_field_hi, cpu_div_field_lo} = '0;
    {sub_clock_cpu_select, synth_cpu_select, int_osc_stop} = '0;
    {main_osc_off, periph_stop_in_wait, clk_out_sel_hi} = '0;
    {clk_out_sel_lo, bus_clk_out_disable, expansion_mode} = '0;
    {wait_mode, stop_enter, synth_run, synth_cfg_wr} = '0;
    {synth_prediv_hi, synth_prediv_lo, synth_mult_hi, synth_mult_lo} = '0;
    {main_osc_level, sub_osc_level, int_osc_level, synth_osc_level} = '0;
    {errors, n_checks, cyc, last, ev_cnt, msel, osc_t} = '0;
    {primed, co_prev} = '0;
    rst_n = 1'b0;
    ce = 1'b1;
    sub_osc_enable = 1'b1;
    periph_source_int_osc = 1'b1;
    seed = 32'hF08326F8;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_val("div8_select_q", 1, div8_select_q);
    chk_mode(CCMS_INT_OSC);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    meas(0, IP * 8);
    wr_div8(1'b0);
    for (int i = 0; i < 4; i++) begin
      set_src(1'b0, 1'b0, 1'b1, 2'(i));
      meas(0, IP * DIV_T[i]);
    end
    wr_div8(1'b1);
    set_src(1'b0, 1'b0, 1'b0, 2'h0);
    meas(0, MP * 8);
    chk_mode(CCMS_MEDIUM);
    wr_div8(1'b0);
    for (int i = 0; i < 7; i++) begin
      seed = xorshift(seed);
      f = (i < 4) ? 2'(i) : seed[1:0];
      set_src(1'b0, 1'b0, 1'b0, f);
      meas(0, MP * DIV_T[f]);
      chk_mode((f == 2'h0) ? CCMS_HIGH : CCMS_MEDIUM);
    end
    wr_div8(1'b1);
    meas(0, MP * 8);
    wr_div8(1'b0);
    synth_run <= 1'b1;
    repeat (20) @(posedge ref_clk);
    set_src(1'b0, 1'b1, 1'b0, 2'h2);
    meas(0, YP * 4);
    chk_mode(CCMS_SYNTH);
    chk_val("synth_enable_q", 1, synth_enable_q);
    set_src(1'b1, 1'b1, 1'b0, 2'h2);
    meas(0, SP);
    set_src(1'b1, 1'b0, 1'b0, 2'h2);
    meas(2, MP);
    chk_mode(CCMS_LOW_SPEED);
    set_src(1'b1, 1'b0, 1'b1, 2'h2);
    meas(2, IP);
    expansion_mode <= 1'b1;
    meas(1, SP);
    bus_clk_out_disable <= 1'b1;
    count_ev(5, 100, c);
    chk_val("bus_clk_low", 0, c);
    main_osc_off <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk_val("div8_select_q", 1, div8_select_q);
    count_ev(2, 100, c);
    chk_val("f1_low_power", 0, c);
    chk_mode(CCMS_LOW_POWER);
    // leave low power before the write
    main_osc_off <= 1'b0;
    wr_div8(1'b0);
    set_src(1'b0, 1'b0, 1'b1, 2'h1);
    main_osc_off <= 1'b1;
    meas(0, IP * 2);
    chk_mode(CCMS_INT_LP);
    main_osc_off <= 1'b0;
    // main settles, then divide by 8
    repeat (20) @(posedge ref_clk);
    wr_div8(1'b1);
    set_src(1'b0, 1'b0, 1'b0, 2'h0);
    {wait_mode, periph_stop_in_wait} <= 2'h3;
    count_ev(2, 100, c);
    chk_val("f1_wait_stop", 0, c);
    chk_mode(CCMS_MEDIUM);
    periph_stop_in_wait <= 1'b0;
    meas(2, MP);
    wait_mode <= 1'b0;
    wr_div8(1'b0);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    @(negedge ref_clk);
    chk_val("div8_select_q", 1, div8_select_q);
    wr_div8(1'b0);
    sub_osc_enable <= 1'b0;
    count_ev(3, 100, c);
    chk_val("sub_tmr_off", 0, c);
    sub_osc_enable <= 1'b1;
    count_ev(3, 100, c);
    chk_val("sub_tmr_on", 1, c > 0);
    int_osc_stop <= 1'b1;
    count_ev(4, 100, c);
    chk_val("int_tmr_off", 0, c);
    int_osc_stop <= 1'b0;
    count_ev(4, 100, c);
    chk_val("int_tmr_on", 1, c > 0);
    {clk_out_sel_hi, clk_out_sel_lo} <= 2'h1;
    count_ev(6, 200, c);
    chk_val("clk_out_bus", 0, c);
    {clk_out_sel_hi, clk_out_sel_lo} <= 2'h0;
    expansion_mode <= 1'b0;
    count_ev(6, 200, c);
    chk_val("clk_out_port", 0, c);
    {clk_out_sel_hi, clk_out_sel_lo} <= 2'h1;
    meas(6, MP * 8);
    {clk_out_sel_hi, clk_out_sel_lo} <= 2'h2;
    meas(6, MP * 32);
    {clk_out_sel_hi, clk_out_sel_lo} <= 2'h3;
    meas(6, SP);
    @(posedge ref_clk);
    synth_cfg_wr <= 1'b1;
    {synth_prediv_hi, synth_prediv_lo, synth_mult_hi, synth_mult_lo} <= 5'h0A;
    @(posedge ref_clk);
    {synth_prediv_hi, synth_prediv_lo, synth_mult_hi, synth_mult_lo} <= 5'h15;
    @(posedge ref_clk);
    synth_cfg_wr <= 1'b0;
    @(negedge ref_clk);
    chk_val("synth_prediv_q", 1, synth_prediv_q);
    chk_val("synth_mult_q", 2, synth_mult_q);
    stop_test();
  end

endmodule : tb_cpu_clock_mode_select
